// *** core/pie_pkg.sv ***
package pie_pkg;
  // decoded 4b symbol codes, control flag separate
  localparam logic [3:0] SYM_I = 4'ha;
  localparam logic [3:0] SYM_H = 4'h1;
  localparam logic [3:0] SYM_J = 4'hd;
  localparam logic [3:0] SYM_K = 4'hd;
  localparam logic [3:0] SYM_V = 4'h0;
  localparam logic [3:0] SYM_R = 4'h6;
  localparam logic [3:0] SYM_S = 4'h7;
  localparam logic [3:0] SYM_T = 4'h5;
  localparam logic [3:0] SYM_Q = 4'h2;
  // second-nibble code of K distinguishes it from J
  localparam logic [3:0] SYM_K2 = 4'he;
  // line state codes
  localparam logic [2:0] LS_ALS = 3'h0;
  localparam logic [2:0] LS_ILS = 3'h1;
  localparam logic [2:0] LS_NSD = 3'h2;
  localparam logic [2:0] LS_ULS = 3'h3;
  localparam logic [2:0] LS_MLS = 3'h4;
  localparam logic [2:0] LS_HLS = 3'h5;
  localparam logic [2:0] LS_QLS = 3'h6;
  localparam logic [2:0] LS_NLS = 3'h7;
  // receive state prefixes and fixed codes
  localparam logic [3:0] RS_PHY_INV = 4'h3;
  localparam logic [3:0] RS_IDLE = 4'hb;
  localparam logic [3:0] DATA_ZERO = 4'h0;
  localparam logic [7:0] CODE_EB_ERR = 8'h3b;
  localparam logic [7:0] CODE_SMT_LSU = 8'h3a;
  localparam logic [7:0] CODE_SCRUB = 8'hb8;
  localparam int CNT_W = 16;
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
endpackage : pie_pkg

// *** core/pie_stream_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface pie_stream_if;
  logic valid;
  logic ready;
  logic [8:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : pie_stream_if
`default_nettype wire

// *** core/pie_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module pie_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  pie_stream_if.snk in_s,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_s.ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_o = (cnt_reg != '0);
  assign push = in_s.valid && in_s.ready;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[rd_reg];
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_s.data;
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule : pie_fifo
`default_nettype wire

// *** core/pie_lem.sv ***
`timescale 1ns/100ps
`default_nettype none
module pie_lem (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [15:0] threshold_i,
  input wire logic link_err_i,
  input wire logic snap_i,
  output logic [15:0] snapshot_o,
  output logic expired_o
);
  logic [15:0] cnt_reg;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= pie_pkg::CNT_ZERO;
    end else if (load_i) begin
      cnt_reg <= threshold_i; // RQ1
    end else if (link_err_i && cnt_reg != pie_pkg::CNT_ZERO) begin
      cnt_reg <= cnt_reg - pie_pkg::CNT_ONE; // RQ1 RQ18
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      snapshot_o <= pie_pkg::CNT_ZERO;
    end else if (snap_i) begin
      snapshot_o <= cnt_reg; // RQ2
    end
  end
  assign expired_o = (cnt_reg == pie_pkg::CNT_ZERO);
endmodule : pie_lem
`default_nettype wire

// *** core/pie_top.sv ***
// Summary of operation
// (RQ1) link error counter counts down from threshold on each link error
// (RQ2) software captures a snapshot of the link error count
// (RQ3) noise on signal without clock, or invalid byte in invalid state
// (RQ4) noise when a data or R/S/T control pair follows an idle pair
// (RQ5) invalid state: halt, quiet, master, noise, or unknown after active/idle
// (RQ6) link errors: bad pairs in active, signal loss, non II/JK in idle
// (RQ7) flag sets on HH, NH, RH, SH, TH in active
// (RQ8) flag clears on JK in active/idle or on unknown-state error
// (RQ9) unknown after active with flag, no stuff, not HH/HI/II/JK errs
// (RQ10) JK enters active; data bytes control 0, others control 1
// (RQ11) mixed byte has data nibble zeroed and is sent as control
// (RQ12) idle state gives idle code, known if both idle else unknown
// (RQ13) line code is receive state, known bit b3, current line state b2-0
// (RQ14) other states give invalid code, known only if both match
// (RQ15) stuff byte: known idle in idle, invalid code elsewhere
// (RQ16) fixed codes for buffer error, unknown-state connection, scrub
// (RQ17) noise counter decrements on noise/unknown/active, reloads on JK, T, signal loss or other states
// (RQ18) link error counter sticks at zero until reloaded
`timescale 1ns/100ps
`default_nettype none
module pie_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sig_detect_i,
  input wire logic clk_detect_i,
  input wire logic sym_valid_i,
  input wire logic [3:0] sym1_i,
  input wire logic sym1_ctl_i,
  input wire logic [3:0] sym2_i,
  input wire logic sym2_ctl_i,
  input wire logic [2:0] line_state_i,
  input wire logic stuff_byte_i,
  input wire logic elasticity_buf_err_i,
  input wire logic smt_lsu_conn_i,
  input wire logic scrub_pair_i,
  input wire logic lem_load_i,
  input wire logic [15:0] link_err_threshold_i,
  input wire logic lem_snap_i,
  output logic [15:0] link_err_count_snapshot_o,
  output logic lem_expired_o,
  input wire logic [15:0] noise_threshold_i,
  output logic noise_expired_o,
  output logic noise_event_o,
  output logic link_err_o,
  output logic link_err_flag_o,
  output logic ind_valid_o,
  input wire logic ind_ready_i,
  output logic [8:0] ind_data_o,
  output logic sym_ready_o
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers for the detect inputs
  logic [1:0] sd_sync_reg;
  logic [1:0] cd_sync_reg;
  logic sd;
  logic cd;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sd_sync_reg <= 2'h0;
      cd_sync_reg <= 2'h0;
    end else begin
      sd_sync_reg <= {sd_sync_reg[0], sig_detect_i};
      cd_sync_reg <= {cd_sync_reg[0], clk_detect_i};
    end
  end
  assign sd = sd_sync_reg[1];
  assign cd = cd_sync_reg[1];
  ////////////////////////////////////////////////////////////////////////
  // symbol classification
  logic take;
  logic is_ii;
  logic is_jk;
  logic is_hh;
  logic is_hi;
  logic data1;
  logic data2;
  logic any_b;
  logic mixed;
  logic bad_active;
  logic flag_set;
  logic match1;
  logic match2;
  logic [2:0] ls;
  logic [2:0] prev_line_state_reg;
  logic prev_byte_ii_reg;
  logic link_err_flag_reg;
  logic phy_invalid_cond;
  logic uls_err;
  function automatic logic is_c(input logic ctl, input logic [3:0] s,
                                input logic [3:0] code);
    is_c = ctl && (s == code);
  endfunction : is_c
  // n + r + s + t; idle is not included
  function automatic logic is_a(input logic ctl, input logic [3:0] s);
    is_a = !ctl || is_c(ctl, s, pie_pkg::SYM_R) ||
           is_c(ctl, s, pie_pkg::SYM_S) || is_c(ctl, s, pie_pkg::SYM_T);
  endfunction : is_a
  // symbol consistent with a non-active line state
  function automatic logic ls_match(input logic ctl, input logic [3:0] s,
                                    input logic [2:0] st);
    case (st)
      pie_pkg::LS_HLS: ls_match = is_c(ctl, s, pie_pkg::SYM_H);
      pie_pkg::LS_QLS: ls_match = is_c(ctl, s, pie_pkg::SYM_Q);
      pie_pkg::LS_MLS: ls_match = is_c(ctl, s, pie_pkg::SYM_H) ||
                                  is_c(ctl, s, pie_pkg::SYM_Q);
      pie_pkg::LS_ILS: ls_match = is_c(ctl, s, pie_pkg::SYM_I);
      default: ls_match = 1'b0;
    endcase
  endfunction : ls_match
  assign take = sym_valid_i && sym_ready_o;
  assign ls = line_state_i;
  assign data1 = !sym1_ctl_i;
  assign data2 = !sym2_ctl_i;
  assign is_ii = is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_I) &&
                 is_c(sym2_ctl_i, sym2_i, pie_pkg::SYM_I);
  assign is_jk = is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_J) &&
                 is_c(sym2_ctl_i, sym2_i, pie_pkg::SYM_K2);
  assign is_hh = is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_H) &&
                 is_c(sym2_ctl_i, sym2_i, pie_pkg::SYM_H);
  assign is_hi = is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_H) &&
                 is_c(sym2_ctl_i, sym2_i, pie_pkg::SYM_I);
  assign any_b = is_a(sym1_ctl_i, sym1_i) && is_a(sym2_ctl_i, sym2_i);
  assign mixed = data1 ^ data2;
  assign match1 = ls_match(sym1_ctl_i, sym1_i, ls);
  assign match2 = ls_match(sym2_ctl_i, sym2_i, ls);
  assign phy_invalid_cond = (ls == pie_pkg::LS_HLS) ||
    (ls == pie_pkg::LS_QLS) || (ls == pie_pkg::LS_MLS) ||
    (ls == pie_pkg::LS_NLS) || ((ls == pie_pkg::LS_ULS) &&
    ((prev_line_state_reg == pie_pkg::LS_ALS) ||
     (prev_line_state_reg == pie_pkg::LS_ILS))); // RQ5
  // idle followed by a non-idle, violation in either half, or broken halt
  assign bad_active =
    (is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_I) &&
     !is_c(sym2_ctl_i, sym2_i, pie_pkg::SYM_I)) ||
    is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_V) ||
    is_c(sym2_ctl_i, sym2_i, pie_pkg::SYM_V) ||
    (is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_H) &&
     !is_c(sym2_ctl_i, sym2_i, pie_pkg::SYM_H));
  assign flag_set = (ls == pie_pkg::LS_ALS) &&
    is_c(sym2_ctl_i, sym2_i, pie_pkg::SYM_H) && (data1 ||
    is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_H) ||
    is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_R) ||
    is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_S) ||
    is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_T)); // RQ7
  assign uls_err = (ls == pie_pkg::LS_ULS) &&
    (prev_line_state_reg == pie_pkg::LS_ALS) && link_err_flag_reg &&
    !stuff_byte_i && !(is_hh || is_hi || is_ii || is_jk); // RQ9
  ////////////////////////////////////////////////////////////////////////
  // noise and link error events
  logic noise_next;
  logic lerr_next;
  always_comb begin
    noise_next = sd && !cd; // RQ3
    if (sd && cd && phy_invalid_cond && !(is_ii || is_jk || any_b)) begin
      noise_next = 1'b1; // RQ3
    end
    if (sd && cd && !phy_invalid_cond && prev_byte_ii_reg && any_b) begin
      noise_next = 1'b1; // RQ4
    end
    lerr_next = 1'b0;
    if (ls == pie_pkg::LS_ALS && (bad_active || !sd)) begin
      lerr_next = 1'b1; // RQ6
    end
    if (ls == pie_pkg::LS_ILS && (!(is_ii || is_jk) || !sd)) begin
      lerr_next = 1'b1; // RQ6
    end
    if (uls_err) begin
      lerr_next = 1'b1; // RQ9
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      noise_event_o <= 1'b0;
      link_err_o <= 1'b0;
    end else begin
      noise_event_o <= take && noise_next;
      link_err_o <= take && lerr_next;
    end
  end
  // set wins over a clear in the same byte
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_err_flag_reg <= 1'b0;
    end else if (take) begin
      if (flag_set) begin
        link_err_flag_reg <= 1'b1; // RQ7
      end else if ((is_jk && (ls == pie_pkg::LS_ALS ||
                   ls == pie_pkg::LS_ILS)) || uls_err) begin
        link_err_flag_reg <= 1'b0; // RQ8
      end
    end
  end
  assign link_err_flag_o = link_err_flag_reg;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_line_state_reg <= pie_pkg::LS_QLS;
      prev_byte_ii_reg <= 1'b0;
    end else if (take) begin
      prev_byte_ii_reg <= is_ii;
      if (ls != pie_pkg::LS_ULS) begin
        prev_line_state_reg <= ls;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // noise counter; expiry flags a line state held too long
  logic [15:0] noise_cnt_reg;
  logic noise_dec;
  assign noise_dec = (ls == pie_pkg::LS_NLS) || (ls == pie_pkg::LS_ULS) ||
                     (ls == pie_pkg::LS_ALS);
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      noise_cnt_reg <= pie_pkg::CNT_ZERO;
    end else if (take) begin
      if (!sd || !noise_dec || is_jk ||
          is_c(sym1_ctl_i, sym1_i, pie_pkg::SYM_T)) begin
        noise_cnt_reg <= noise_threshold_i; // RQ17
      end else if (noise_cnt_reg != pie_pkg::CNT_ZERO) begin
        noise_cnt_reg <= noise_cnt_reg - pie_pkg::CNT_ONE; // RQ17
      end
    end
  end
  assign noise_expired_o = (noise_cnt_reg == pie_pkg::CNT_ZERO);
  pie_lem u_lem (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(lem_load_i),
    .threshold_i(link_err_threshold_i),
    .link_err_i(link_err_o),
    .snap_i(lem_snap_i),
    .snapshot_o(link_err_count_snapshot_o),
    .expired_o(lem_expired_o)
  ); // RQ1 RQ2 RQ18
  ////////////////////////////////////////////////////////////////////////
  // indicate code builder: {control, hi nibble, lo nibble}
  logic [8:0] code;
  always_comb begin
    code = {1'b1, pie_pkg::RS_PHY_INV, 1'b1, ls};
    if (elasticity_buf_err_i) begin
      code = {1'b1, pie_pkg::CODE_EB_ERR}; // RQ16
    end else if (smt_lsu_conn_i) begin
      code = {1'b1, pie_pkg::CODE_SMT_LSU}; // RQ16
    end else if (scrub_pair_i) begin
      code = {1'b1, pie_pkg::CODE_SCRUB}; // RQ16
    end else if (ls == pie_pkg::LS_ALS && !stuff_byte_i) begin
      if (data1 && data2) begin
        code = {1'b0, sym1_i, sym2_i}; // RQ10
      end else if (mixed) begin
        code = {1'b1, data1 ? pie_pkg::DATA_ZERO : sym1_i,
                data2 ? pie_pkg::DATA_ZERO : sym2_i}; // RQ11
      end else begin
        code = {1'b1, sym1_i, sym2_i}; // RQ10
      end
    end else if (ls == pie_pkg::LS_ILS) begin
      code = {1'b1, pie_pkg::RS_IDLE, !(is_ii || stuff_byte_i),
              pie_pkg::LS_ILS}; // RQ12 RQ13 RQ15
    end else begin
      // stuff bytes outside idle report known against current state
      code = {1'b1, pie_pkg::RS_PHY_INV,
              !((match1 && match2) || stuff_byte_i), ls}; // RQ14 RQ15
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // output buffering; a full fifo stalls the decoder
  pie_stream_if ind_s ();
  assign ind_s.valid = sym_valid_i;
  assign ind_s.data = code;
  assign sym_ready_o = ind_s.ready;
  pie_fifo #(
    .WIDTH(pie_pkg::FIFO_W),
    .DEPTH(pie_pkg::FIFO_D)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_s(ind_s),
    .out_valid_o(ind_valid_o),
    .out_ready_i(ind_ready_i),
    .out_data_o(ind_data_o)
  );
endmodule : pie_top
`default_nettype wire

// *** verification/pie_mac_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pie_mac_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic [8:0] data_i,
  input wire logic stall_i,
  output logic ready_o
);
  logic [8:0] got[$];
  initial ready_o = 1'b0;
  // a word counts only on the edge that sees valid and ready together
  always @(posedge core_clk_i) begin
    if (!rst_i && valid_i && ready_o)
      got.push_back(data_i);
    #1 ready_o = !stall_i && !rst_i;
  end
endmodule : pie_mac_model
`default_nettype wire

// *** verification/pie_top_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module pie_top_assertions (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sig_detect_i,
  input wire logic clk_detect_i,
  input wire logic sym_valid_i,
  input wire logic [3:0] sym1_i,
  input wire logic sym1_ctl_i,
  input wire logic [3:0] sym2_i,
  input wire logic sym2_ctl_i,
  input wire logic [2:0] line_state_i,
  input wire logic stuff_byte_i,
  input wire logic elasticity_buf_err_i,
  input wire logic smt_lsu_conn_i,
  input wire logic scrub_pair_i,
  input wire logic lem_load_i,
  input wire logic lem_snap_i,
  input wire logic [15:0] link_err_count_snapshot_o,
  input wire logic lem_expired_o,
  input wire logic noise_event_o,
  input wire logic link_err_flag_o,
  input wire logic ind_valid_o,
  input wire logic [8:0] ind_data_o,
  input wire logic sym_ready_o
);
  logic [2:0] sd_h;
  logic [2:0] cd_h;
  wire logic tk0 = sym_valid_i && sym_ready_o;
  // empty fifo, so the word shows on the very next cycle
  wire logic tk = tk0 && !ind_valid_o;
  wire logic pl = !(stuff_byte_i | elasticity_buf_err_i |
    smt_lsu_conn_i | scrub_pair_i);
  wire logic cc = sym1_ctl_i && sym2_ctl_i && pl;
  wire logic als = line_state_i == pie_pkg::LS_ALS;
  // detects pass a synchronizer: only trust levels held a while
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sd_h <= 3'h0;
      cd_h <= 3'h7;
    end else begin
      sd_h <= {sd_h[1:0], sig_detect_i};
      cd_h <= {cd_h[1:0], clk_detect_i};
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_data_pass: assert property (tk && pl && als && !sym1_ctl_i &&
    !sym2_ctl_i |=> ind_valid_o && ind_data_o == {1'b0, $past(sym1_i),
    $past(sym2_i)}) else $error("data pair not forwarded");
  chk_mixed_zero: assert property (tk && pl && als && !sym1_ctl_i &&
    sym2_ctl_i |=> ind_data_o == {1'b1, 4'h0, $past(sym2_i)})
    else $error("mixed pair not zeroed");
  chk_idle_known: assert property (tk && cc &&
    sym1_i == pie_pkg::SYM_I &&
    sym2_i == pie_pkg::SYM_I && line_state_i == pie_pkg::LS_ILS |=>
    ind_data_o == 9'h1b1) else $error("idle code wrong");
  chk_buf_err: assert property (tk && elasticity_buf_err_i |=>
    ind_data_o == {1'b1, pie_pkg::CODE_EB_ERR}) else $error("buffer code");
  chk_flag_set: assert property (tk0 && cc && als &&
    sym1_i == pie_pkg::SYM_H && sym2_i == pie_pkg::SYM_H |=>
    link_err_flag_o) else $error("flag not set");
  chk_flag_clear: assert property (tk0 && cc && als &&
    sym1_i == pie_pkg::SYM_J && sym2_i == pie_pkg::SYM_K2 |=>
    !link_err_flag_o) else $error("flag not cleared");
  chk_noise_noclk: assert property (tk0 && (&sd_h) && !(|cd_h) &&
    sig_detect_i && !clk_detect_i |=> noise_event_o)
    else $error("noise missed");
  chk_lem_floor: assert property (lem_snap_i && lem_expired_o &&
    !lem_load_i |=> link_err_count_snapshot_o == 16'h0000)
    else $error("counter left zero");
  cov_full: cover property (sym_valid_i && !sym_ready_o);
  cov_flag: cover property ($rose(link_err_flag_o));
  cov_noise: cover property (noise_event_o);
endmodule : pie_top_assertions
bind pie_top pie_top_assertions u_chk (.*);
`default_nettype wire

// *** verification/pie_top_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", n, e, g); end end
module pie_top_test;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sig_detect_i = 1'b1;
  logic clk_detect_i = 1'b1;
  logic sym_valid_i = 1'b0;
  logic [3:0] sym1_i = 4'h0, sym2_i = 4'h0;
  logic sym1_ctl_i = 1'b0, sym2_ctl_i = 1'b0;
  logic [2:0] line_state_i = 3'h1;
  logic stuff_byte_i = 1'b0, elasticity_buf_err_i = 1'b0;
  logic smt_lsu_conn_i = 1'b0, scrub_pair_i = 1'b0;
  logic lem_load_i = 1'b0, lem_snap_i = 1'b0, stall = 1'b0;
  logic [15:0] link_err_threshold_i = 16'h0000;
  logic [15:0] noise_threshold_i = 16'h0100;
  logic [15:0] link_err_count_snapshot_o;
  logic lem_expired_o, noise_expired_o, noise_event_o, link_err_o;
  logic link_err_flag_o, ind_valid_o, ind_ready_i, sym_ready_o;
  logic [8:0] ind_data_o, w;
  int miscompares = 0, num_checks = 0, cyc = 0, nz = 0, le = 0, n;
  pie_top DUT (.*);
  pie_mac_model MAC (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .valid_i(ind_valid_o), .data_i(ind_data_o), .stall_i(stall),
    .ready_o(ind_ready_i));
  always #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (noise_event_o === 1'b1) nz++;
    if (link_err_o === 1'b1) le++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task tick;
    @(posedge core_clk_i);
    #1;
  endtask : tick
  ////////////////////////////////////////////////////////////////////////////
  // q packs stuff, buffer error, lsu connection, scrub; wt waits the word
  task put(input logic [2:0] ls, input logic [3:0] a, input logic ca,
    input logic [3:0] b, input logic cb, input logic [3:0] q, input bit wt);
    int k;
    k = MAC.got.size();
    line_state_i = ls;
    sym1_i = a;
    sym1_ctl_i = ca;
    sym2_i = b;
    sym2_ctl_i = cb;
    {stuff_byte_i, elasticity_buf_err_i, smt_lsu_conn_i, scrub_pair_i} = q;
    sym_valid_i = 1'b1;
    while (sym_ready_o !== 1'b1) tick();
    tick();
    if (wt) begin
      sym_valid_i = 1'b0;
      do tick(); while (MAC.got.size() <= k);
      w = MAC.got[$];
    end
  endtask : put
  task cc(input logic [2:0] ls, input logic [3:0] a, input logic [3:0] b,
    input logic [3:0] q);
    put(ls, a, 1'b1, b, 1'b1, q, 1'b1);
  endtask : cc
  task snap;
    lem_snap_i = 1'b1;
    tick();
    lem_snap_i = 1'b0;
    tick();
  endtask : snap
  ////////////////////////////////////////////////////////////////////////////
  // line states: 0 active, 1 idle, 3 unknown, 5 halt
  task t_codes;
    cc(3'h1, 4'ha, 4'ha, 4'h0); `CHK("ii", 9'h1b1, w)
    `CHK("noise expired", 1'b0, noise_expired_o)
    cc(3'h1, 4'h1, 4'ha, 4'h0); `CHK("hi", 9'h1b9, w)
    cc(3'h1, 4'h1, 4'h1, 4'h8); `CHK("stuff", 9'h1b1, w)
    cc(3'h0, 4'hd, 4'he, 4'h0); `CHK("jk", 9'h1de, w)
    put(3'h0, 4'h3, 1'b0, 4'h4, 1'b0, 4'h0, 1'b1);
    `CHK("nn", 9'h034, w)
    put(3'h0, 4'h5, 1'b0, 4'h5, 1'b1, 4'h0, 1'b1);
    `CHK("nc", 9'h105, w)
    put(3'h0, 4'h6, 1'b1, 4'h9, 1'b0, 4'h0, 1'b1);
    `CHK("cn", 9'h160, w)
    cc(3'h5, 4'h1, 4'h1, 4'h0); `CHK("hh", 9'h135, w)
    cc(3'h5, 4'ha, 4'ha, 4'h0); `CHK("halt ii", 9'h13d, w)
    cc(3'h1, 4'ha, 4'ha, 4'h4); `CHK("eb", 9'h13b, w)
    cc(3'h1, 4'ha, 4'ha, 4'h2); `CHK("lsu", 9'h13a, w)
    cc(3'h1, 4'ha, 4'ha, 4'h1); `CHK("scrub", 9'h1b8, w)
  endtask : t_codes
  task t_lem;
    `CHK("expired", 1'b1, lem_expired_o)
    link_err_threshold_i = 16'h0002;
    lem_load_i = 1'b1;
    tick();
    lem_load_i = 1'b0;
    snap(); `CHK("count", 16'h0002, link_err_count_snapshot_o)
    for (int i = 1; i <= 3; i++) begin
      cc(3'h1, 4'h1, 4'h1, 4'h0);
      snap();
      `CHK("count", (i < 2) ? 16'h0001 : 16'h0000,
        link_err_count_snapshot_o)
    end
    `CHK("expired", 1'b1, lem_expired_o)
  endtask : t_lem
  task t_flag;
    cc(3'h0, 4'h1, 4'h1, 4'h0); `CHK("flag", 1'b1, link_err_flag_o)
    n = le;
    cc(3'h3, 4'h6, 4'h6, 4'h0);
    tick(); `CHK("lerr", n + 1, le)
    `CHK("flag", 1'b0, link_err_flag_o)
    cc(3'h0, 4'h1, 4'h1, 4'h0);
    cc(3'h0, 4'hd, 4'he, 4'h0); `CHK("flag", 1'b0, link_err_flag_o)
  endtask : t_flag
  task t_noise;
    clk_detect_i = 1'b0;
    repeat (4) tick();
    n = nz;
    cc(3'h1, 4'ha, 4'ha, 4'h0);
    tick(); `CHK("noise", n + 1, nz)
    clk_detect_i = 1'b1;
    repeat (4) tick();
    cc(3'h1, 4'ha, 4'ha, 4'h0);
    n = nz;
    put(3'h0, 4'h3, 1'b0, 4'h4, 1'b0, 4'h0, 1'b1);
    tick(); `CHK("noise", n + 1, nz)
  endtask : t_noise
  // far side stalls until the fifo refuses, then drains it
  task t_fill;
    stall = 1'b1;
    tick();
    tick();
    MAC.got.delete();
    for (int i = 0; i < 16; i++)
      put(3'h0, i[3:0], 1'b0, ~i[3:0], 1'b0, 4'h0, 1'b0);
    `CHK("ready", 1'b0, sym_ready_o)
    sym_valid_i = 1'b0;
    stall = 1'b0;
    while (MAC.got.size() < 16) tick();
    for (int i = 0; i < 16; i++)
      `CHK("fifo", {1'b0, i[3:0], ~i[3:0]}, MAC.got[i])
    tick(); `CHK("empty", 1'b0, ind_valid_o)
  endtask : t_fill
  initial begin
    repeat (10) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    tick();
    t_codes();
    t_lem();
    t_flag();
    t_noise();
    t_fill();
    end_sim();
  end
endmodule : pie_top_test
`default_nettype wire
